// file: hdl/motion_fault_protection.sv
// Function
// - Motor-off command drops that axis's amplifier permit.
// - Following error beyond the limit drops that axis's permit.
// - Abort with fault-disable set drops that axis's permit.
// - Watchdog trip drops every permit; reset drives every permit low, which drops them in the default polarity only.
// - Each axis has its own permit; axis faults affect only that axis.
// - Permit is active high by default; polarity can be set active low.
// - Fault output low and error light on while any error exists.
// - Global abort low ends all commanded motion at once, no ramp.
// - Abort with fault-disable set disables amplifier; motor coasts.
// - Abort without fault-disable stops and holds position under servo.
// - Abort halts program by default; a config bit disables the halt.
// - Selective abort mode gives each axis its own abort input.
// - Selective abort acts like global abort but only on its axis.
// - Following error is command minus encoder; fault when magnitude exceeds limit.
`timescale 1ns/10ps
`default_nettype none
`include "motion_fault_consts.svh"

module motion_fault_protection #(
    parameter int N = `MFP_NUM_AXES,
    parameter int PW = `MFP_POS_W
) (
    // Clock and reset.
    input  wire logic            CLK_I,
    input  wire logic            ARST_N_I,
    // Commands from the servo processor, one-cycle pulses; motor-off and servo-here are per axis.
    input  wire logic [N-1:0]    MOTOR_OFF_I,
    input  wire logic [N-1:0]    SERVO_HERE_I,
    input  wire logic            ABORT_CMD_I,
    input  wire logic            WATCHDOG_TRIP_I,
    // Configuration levels.
    input  wire logic [N-1:0]    DISABLE_ON_FAULT_MODE_ONE_I,
    input  wire logic            PERMIT_ACTIVE_HIGH_I,
    input  wire logic            ABORT_HALT_DISABLE_I,
    input  wire logic            SELECTIVE_ABORT_EN_I,
    // Positions and limits, packed per axis.
    input  wire logic [N*PW-1:0] CMD_POS_I,
    input  wire logic [N*PW-1:0] ENC_POS_I,
    input  wire logic [N*PW-1:0] FOLLOWING_LIMIT_VALUE_I,
    // Pins from outside, active low.
    input  wire logic            ABORT_N_I,
    input  wire logic [N-1:0]    SEL_ABORT_N_I,
    // Amplifier permits and status.
    output logic      [N-1:0]    AMP_DRIVE_PERMIT_O,
    output logic      [N-1:0]    AXIS_HOLD_O,
    output logic      [N-1:0]    FOLLOW_FAULT_O,
    output logic                 MOTION_STOP_O,
    output logic                 PROGRAM_HALT_O,
    output logic                 FAULT_N_O,
    output logic                 ERROR_LED_O
);

    // ------------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------------
    logic         abort_lvl_n;
    logic [N-1:0] sel_lvl_n;

    // Global abort pin.
    input_sync3 #(.W(1), .RST(1'b1)) u_sync_abort (
        .clk_i    (CLK_I),
        .arst_n_i (ARST_N_I),
        .async_i  (ABORT_N_I),
        .level_o  (abort_lvl_n)
    );

    // Selective abort pins.
    input_sync3 #(.W(N), .RST({N{1'b1}})) u_sync_sel (
        .clk_i    (CLK_I),
        .arst_n_i (ARST_N_I),
        .async_i  (SEL_ABORT_N_I),
        .level_o  (sel_lvl_n)
    );

    // ------------------------------------------------------------------------
    // Per-axis fault evaluation
    // ------------------------------------------------------------------------
    logic [N-1:0] ferr;
    logic [N-1:0] ax_abort;
    logic         glob_abort;

    // Global abort pin level or abort command pulse.
    assign glob_abort = !abort_lvl_n || ABORT_CMD_I;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_axis
            logic signed [PW:0] diff;
            logic        [PW:0] mag;
            // Following error as command minus encoder, sign-extended.
            assign diff = {CMD_POS_I[g*PW+PW-1], CMD_POS_I[g*PW +: PW]}
                        - {ENC_POS_I[g*PW+PW-1], ENC_POS_I[g*PW +: PW]};
            assign mag  = diff[PW] ? (PW+1)'(-diff) : diff;
            // Fault when magnitude exceeds the limit.
            assign ferr[g] = mag > {1'b0, FOLLOWING_LIMIT_VALUE_I[g*PW +: PW]};
            // Selective pin acts on its own axis only.
            assign ax_abort[g] = glob_abort || (SELECTIVE_ABORT_EN_I && !sel_lvl_n[g]);
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Axis state machines
    // ------------------------------------------------------------------------
    motion_fault_pkg::axis_state_t st_q [N];
    motion_fault_pkg::axis_state_t st_d [N];
    logic [N-1:0] permit_d, permit_q, hold_d, hold_q, ff_d, ff_q;
    logic         stop_d, stop_q, halt_d, halt_q, fault_n_d, fault_n_q;
    logic         led_d, led_q;

    // Next axis states; each axis decides from its own conditions.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            st_d[i] = st_q[i];
            case (st_q[i])
                motion_fault_pkg::AX_OFF: begin
                    if (SERVO_HERE_I[i] && !WATCHDOG_TRIP_I && !ferr[i]) begin
                        st_d[i] = motion_fault_pkg::AX_SERVO;
                    end
                end
                motion_fault_pkg::AX_SERVO, motion_fault_pkg::AX_HOLD: begin
                    if (ax_abort[i] && !DISABLE_ON_FAULT_MODE_ONE_I[i]) begin
                        st_d[i] = motion_fault_pkg::AX_HOLD;
                    end else if (st_q[i] == motion_fault_pkg::AX_HOLD && SERVO_HERE_I[i]) begin
                        st_d[i] = motion_fault_pkg::AX_SERVO;
                    end
                end
                default: st_d[i] = motion_fault_pkg::AX_OFF;
            endcase
            // Disabling conditions override everything.
            if (MOTOR_OFF_I[i] || ferr[i] || WATCHDOG_TRIP_I
                || (ax_abort[i] && DISABLE_ON_FAULT_MODE_ONE_I[i])) begin
                st_d[i] = motion_fault_pkg::AX_OFF;
            end
        end
    end

    // Output next values.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            // Polarity applied to the active level.
            permit_d[i] = (st_d[i] != motion_fault_pkg::AX_OFF) ~^ PERMIT_ACTIVE_HIGH_I;
            hold_d[i]   = (st_d[i] == motion_fault_pkg::AX_HOLD);
        end
        ff_d      = ferr;
        stop_d    = glob_abort;
        halt_d    = glob_abort && !ABORT_HALT_DISABLE_I;
        fault_n_d = !(|ferr || |ax_abort || WATCHDOG_TRIP_I);
        led_d     = !fault_n_d;
    end

    // Registers; reset leaves all permits inactive in the default polarity.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            for (int i = 0; i < N; i++) begin
                st_q[i] <= motion_fault_pkg::AX_OFF;
            end
            permit_q  <= {N{`MFP_PERMIT_RST}};
            hold_q    <= '0;
            ff_q      <= '0;
            stop_q    <= 1'b0;
            halt_q    <= 1'b0;
            fault_n_q <= 1'b1;
            led_q     <= 1'b0;
        end else begin
            st_q      <= st_d;
            permit_q  <= permit_d;
            hold_q    <= hold_d;
            ff_q      <= ff_d;
            stop_q    <= stop_d;
            halt_q    <= halt_d;
            fault_n_q <= fault_n_d;
            led_q     <= led_d;
        end
    end

    assign AMP_DRIVE_PERMIT_O = permit_q;
    assign AXIS_HOLD_O        = hold_q;
    assign FOLLOW_FAULT_O     = ff_q;
    assign MOTION_STOP_O      = stop_q;
    assign PROGRAM_HALT_O     = halt_q;
    assign FAULT_N_O          = fault_n_q;
    assign ERROR_LED_O        = led_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    a_motor_off_drop: assert property (MOTOR_OFF_I[0] |=>
        AMP_DRIVE_PERMIT_O[0] == !$past(PERMIT_ACTIVE_HIGH_I))
        else $error("Permit stayed active after motor off.");
    a_ferr_drop: assert property (ferr[1] |=>
        (AMP_DRIVE_PERMIT_O[1] == !$past(PERMIT_ACTIVE_HIGH_I)) && FOLLOW_FAULT_O[1])
        else $error("Following error did not drop permit.");
    a_abort_off_drop: assert property ((ax_abort[0] && DISABLE_ON_FAULT_MODE_ONE_I[0]) |=>
        st_q[0] == motion_fault_pkg::AX_OFF)
        else $error("Abort with fault-disable left axis on.");
    a_watchdog_all: assert property (WATCHDOG_TRIP_I |=>
        AMP_DRIVE_PERMIT_O == {N{!$past(PERMIT_ACTIVE_HIGH_I)}})
        else $error("Watchdog left a permit active.");
    a_fault_light: assert property (FAULT_N_O == !ERROR_LED_O)
        else $error("Error light disagrees with fault output.");
    a_fault_cause: assert property (WATCHDOG_TRIP_I |=> !FAULT_N_O)
        else $error("Fault output not low on watchdog.");
    a_abort_hold: assert property ((st_q[2] == motion_fault_pkg::AX_SERVO && glob_abort
        && !DISABLE_ON_FAULT_MODE_ONE_I[2] && !ferr[2] && !MOTOR_OFF_I[2]
        && !WATCHDOG_TRIP_I) |=> AXIS_HOLD_O[2])
        else $error("Axis not held on abort.");
    a_halt_cfg: assert property (glob_abort |=> PROGRAM_HALT_O == !$past(ABORT_HALT_DISABLE_I))
        else $error("Program halt ignores configuration.");
    a_sel_local: assert property ((!glob_abort && !ferr[1] && !MOTOR_OFF_I[1]
        && !WATCHDOG_TRIP_I && st_q[1] == motion_fault_pkg::AX_SERVO && SELECTIVE_ABORT_EN_I
        && !sel_lvl_n[2] && sel_lvl_n[1]) |=> st_q[1] == motion_fault_pkg::AX_SERVO)
        else $error("Selective abort reached another axis.");
    a_pin_sync: assert property ($fell(ABORT_N_I) ##1 !ABORT_N_I [*3] |=> !abort_lvl_n)
        else $error("Synchronised abort did not follow pin.");

    c_servo_on:   cover property (st_q[0] == motion_fault_pkg::AX_SERVO);
    c_hold:       cover property (AXIS_HOLD_O[0]);
    c_sel_abort:  cover property (SELECTIVE_ABORT_EN_I && !sel_lvl_n[2]);
    c_ferr:       cover property (FOLLOW_FAULT_O[1]);

endmodule : motion_fault_protection

`default_nettype wire

// file: hdl/motion_fault_consts.svh
`ifndef MOTION_FAULT_CONSTS_SVH
`define MOTION_FAULT_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define MFP_NUM_AXES      8
`define MFP_POS_W         32
`define MFP_SYNC_STAGES   3
`define MFP_PERMIT_RST    1'b0

`endif

// file: hdl/motion_fault_pkg.sv
// ----------------------------------------------------------------------------
// Types shared by the protection block
// ----------------------------------------------------------------------------
`default_nettype none
package motion_fault_pkg;

    // Per-axis servo state, one-hot.
    typedef enum logic [2:0] {
        AX_OFF   = 3'b001,
        AX_SERVO = 3'b010,
        AX_HOLD  = 3'b100
    } axis_state_t;

endpackage : motion_fault_pkg
`default_nettype wire

// file: hdl/input_sync3.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Three-stage synchroniser with agreement filter
// ----------------------------------------------------------------------------
module input_sync3 #(
    parameter int W   = 1,
    parameter logic [W-1:0] RST = '1
) (
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    // Raw and filtered levels.
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);

    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [W-1:0] s1_d, s2_d, s3_d, lvl_d;

    // Next stage values; a change counts once stages two and three agree.
    always_comb begin
        s1_d  = async_i;
        s2_d  = s1_q;
        s3_d  = s2_q;
        lvl_d = lvl_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end

    // Stage registers.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_q  <= RST;
            s2_q  <= RST;
            s3_q  <= RST;
            lvl_q <= RST;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            lvl_q <= lvl_d;
        end
    end

    assign level_o = lvl_q;

endmodule : input_sync3

`default_nettype wire

// file: tb/far_side_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Far side: abort switches and amplifiers
// ----------------------------------------------------------------------------
module far_side_model (
    // Switch commands from the bench.
    input  wire logic       press_i,
    input  wire logic [7:0] sel_press_i,
    // Amplifier permits and their polarity.
    input  wire logic [7:0] permit_i,
    input  wire logic       active_high_i,
    // Pins towards the block and amplifier state.
    output logic            abort_n_o,
    output logic [7:0]      sel_abort_n_o,
    output logic [7:0]      amp_on_o
);
    // Switch edges land off the clock grid, as a real contact would.
    assign #1.3 abort_n_o = ~press_i;
    assign #2.1 sel_abort_n_o = ~sel_press_i;
    // An amplifier runs while its permit sits at the active level.
    assign amp_on_o = active_high_i ? permit_i : ~permit_i;
endmodule : far_side_model
`default_nettype wire

// file: tb/test_motion_fault_protection.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module test_motion_fault_protection;
    logic         clk, rst_n, wdt, hi, hdis, sel_en, abcmd, press, abort_n;
    logic [7:0]   moff, sh, fdis, selp, sel_n, permit, hold, ff, amp;
    logic [255:0] cmd, enc, lim;
    logic         stop, halt, fault_n, led;
    int           errors, total_checks;

    motion_fault_protection dut (.CLK_I(clk), .ARST_N_I(rst_n), .MOTOR_OFF_I(moff),
        .SERVO_HERE_I(sh), .ABORT_CMD_I(abcmd), .WATCHDOG_TRIP_I(wdt),
        .DISABLE_ON_FAULT_MODE_ONE_I(fdis), .PERMIT_ACTIVE_HIGH_I(hi),
        .ABORT_HALT_DISABLE_I(hdis), .SELECTIVE_ABORT_EN_I(sel_en), .CMD_POS_I(cmd),
        .ENC_POS_I(enc), .FOLLOWING_LIMIT_VALUE_I(lim), .ABORT_N_I(abort_n),
        .SEL_ABORT_N_I(sel_n), .AMP_DRIVE_PERMIT_O(permit), .AXIS_HOLD_O(hold),
        .FOLLOW_FAULT_O(ff), .MOTION_STOP_O(stop), .PROGRAM_HALT_O(halt),
        .FAULT_N_O(fault_n), .ERROR_LED_O(led));
    far_side_model far (.press_i(press), .sel_press_i(selp), .permit_i(permit),
        .active_high_i(hi), .abort_n_o(abort_n), .sel_abort_n_o(sel_n), .amp_on_o(amp));

    // Clock of 5 ns period.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Lets a number of rising edges pass, ending at a falling edge.
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    // Requests servo on every axis.
    task automatic servo_all;
        sh = 8'hFF;
        step(1);
        sh = 8'h00;
        step(1);
    endtask : servo_all

    // Motor-off on one axis leaves the others running.
    task automatic t_motor_off;
        servo_all();
        chk("permit", 8'hFF, permit);
        moff = 8'h01;
        step(1);
        moff = 8'h00;
        step(1);
        chk("permit", 8'hFE, permit);
        chk("amp", 8'hFE, amp);
    endtask : t_motor_off

    // Following error at and just beyond the limit.
    task automatic t_follow;
        servo_all();
        cmd[32+:32] = 32'h0000_0064;
        step(2);
        chk("ferr", 8'h00, ff);
        enc[32+:32] = 32'hFFFF_FFFF;
        step(2);
        chk("ferr", 8'h02, ff);
        chk("permit", 8'hFD, permit);
        chk("fault_n", 8'h00, {7'h00, fault_n});
        chk("led", 8'h01, {7'h00, led});
        enc[32+:32] = 32'h0000_0064;
        step(2);
        chk("fault_n", 8'h01, {7'h00, fault_n});
    endtask : t_follow

    // Global abort: axis 0 coasts, the rest hold, program halts when hd is low.
    task automatic t_abort(input logic hd);
        fdis = 8'h01;
        hdis = hd;
        servo_all();
        press = 1'b1;
        step(2);
        chk("stop", 8'h00, {7'h00, stop});
        step(5);
        chk("stop", 8'h01, {7'h00, stop});
        chk("permit", 8'hFE, permit);
        chk("hold", 8'hFE, hold);
        chk("halt", {7'h00, ~hd}, {7'h00, halt});
        press = 1'b0;
        step(7);
        servo_all();
        chk("hold", 8'h00, hold);
        chk("permit", 8'hFF, permit);
    endtask : t_abort

    // Software abort with fault-disable on axis 0.
    task automatic t_abort_cmd;
        abcmd = 1'b1;
        step(1);
        abcmd = 1'b0;
        chk("permit0", 8'h00, {7'h00, permit[0]});
        chk("hold", 8'hFE, hold);
        chk("stop", 8'h01, {7'h00, stop});
        servo_all();
    endtask : t_abort_cmd

    // Selective abort is ignored until enabled, then acts on its axis.
    task automatic t_sel;
        fdis = 8'h04;
        selp = 8'h04;
        step(7);
        chk("permit", 8'hFF, permit);
        sel_en = 1'b1;
        step(7);
        chk("permit", 8'hFB, permit);
        chk("stop", 8'h00, {7'h00, stop});
        selp = 8'h00;
        sel_en = 1'b0;
        step(7);
        servo_all();
    endtask : t_sel

    // Watchdog drops every permit, then active-low polarity.
    task automatic t_wdt_pol;
        wdt = 1'b1;
        step(2);
        chk("permit", 8'h00, permit);
        wdt = 1'b0;
        hi = 1'b0;
        servo_all();
        chk("permit", 8'h00, permit);
        chk("amp", 8'hFF, amp);
    endtask : t_wdt_pol

    // Prints the counts and the verdict.
    task automatic results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // Main sequence.
    initial begin
        errors = 0;
        total_checks = 0;
        {rst_n, wdt, hdis, sel_en, abcmd, press} = 6'h00;
        hi = 1'b1;
        {moff, sh, fdis, selp} = 32'h0;
        cmd = '0;
        enc = '0;
        lim = {8{32'h0000_0064}};
        step(2);
        chk("permit", 8'h00, permit);
        rst_n = 1'b1;
        step(1);
        t_motor_off();
        t_follow();
        t_abort(1'b0);
        t_abort(1'b1);
        t_abort_cmd();
        t_sel();
        t_wdt_pol();
        results();
    end
endmodule : test_motion_fault_protection
`default_nettype wire
